// [ddrct_top.sv]
// command timing logic inside a ddr3 device: write start, power-down,
// calibration, termination hold and spacing violation tracking
// assumes command pins are synchronous to clock; registers on a plain port
//
// Chosen here: the plain strobed port and the register offsets.
`include "ddrct_cfg.svh"
module ddrct_top
  import ddrct_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic        odt,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  output logic             write_start,
  output logic             low_power,
  output logic             zq_busy,
  output logic             dll_ready,
  output logic             reinit_needed
);

  // larger of a cycle count and a time rounded up to cycles
  function automatic logic [11:0] cyc_max(input int counted_clock_cycles, input int ns);
    int t;
    t = ((ns * `PS_PER_NS) + `TCK_PS - 1) / `TCK_PS;
    if (t < counted_clock_cycles) begin
      t = counted_clock_cycles;
    end
    if (t < 1) begin
      t = 1;
    end
    return t[11:0];
  endfunction

  localparam logic [11:0] XP_CYC    = cyc_max(`XP_NCK, `XP_NS);      // R18
  localparam logic [11:0] XPDLL_CYC = cyc_max(`XPDLL_NCK, `XPDLL_NS); // R17
  localparam logic [11:0] REFI_CYC  = cyc_max(1, `REFI_NS);          // R3
  localparam logic [11:0] REF_LIMIT = 12'(`REF_MAX_GAP * REFI_CYC);   // R12

  // command decode
  logic [3:0]  cmd_code;   // raw command pins
  logic        cmd_valid;  // chip selected with clock enable high while in PD_RUN
  logic        is_mrs;     // mode register set
  logic        is_ref;     // refresh
  logic        is_pre;     // precharge
  logic        is_act;     // activate
  logic        is_wr;      // write
  logic        is_rd;      // read
  logic        is_short_calibration_cmd;    // short calibration
  logic        any_cmd;    // anything other than a no-op

  // registers
  logic [31:0] ctrl;          // latencies written by software
  logic [1:0]  mr_bl;         // burst mode from first mode register
  logic [2:0]  mr_wr;         // write recovery cycles
  logic        mpr_on;        // readout pattern register enabled
  logic        cke_q;         // clock enable seen at previous edge
  logic        odt_q;         // termination seen at previous edge
  logic        ref_seen;      // a refresh has been registered
  logic [`NVIOL-1:0] viol;    // sticky spacing violations
  logic [33:0] wchain;        // write history, bit j = write j+1 ago
  logic        odt_long;      // running hold window is the six-cycle one
  ddrct_pd_t   pd_state;      // power-down progress
  logic [31:0] next_ctrl;
  logic [1:0]  next_mr_bl;
  logic [2:0]  next_mr_wr;
  logic        next_mpr_on;
  logic        next_ref_seen;
  logic [`NVIOL-1:0] next_viol;
  logic [33:0] next_wchain;
  logic        next_odt_long;
  logic        next_write_start;
  ddrct_pd_t   next_pd_state;
  logic [31:0] next_rdata;

  // timers
  logic [`NTIMERS-1:0] t_load;           // reload strobes
  logic [11:0]         t_val [`NTIMERS]; // reload values
  logic [11:0]         t_cnt [`NTIMERS]; // running counts
  logic [`NTIMERS-1:0] t_idle;           // count at zero

  logic [4:0]  wl;          // write latency in cycles
  logic [4:0]  rl;          // read latency in cycles
  logic [5:0]  wdelay;      // write command to internal start
  logic [5:0]  wtap;        // history tap feeding the start flag
  logic        chop_fixed;  // chop-four fixed by mode register
  logic        otf_chop;    // on-the-fly chop requested on this write
  logic        locked_cmd;  // command needing a locked loop
  logic        cke_fall;    // clock enable registered low this cycle
  logic        odt_rise;    // termination first registered high
  logic        odt_fall;    // termination registered low
  logic        viol_clr;    // software clearing violations

  assign cmd_code   = {cs_n, ras_n, cas_n, we_n};
  assign cmd_valid  = cke && !cs_n && (pd_state == PD_RUN);
  assign is_mrs     = cmd_valid && (cmd_code == CMD_MRS);
  assign is_ref     = cmd_valid && (cmd_code == CMD_REF);
  assign is_pre     = cmd_valid && (cmd_code == CMD_PRE);
  assign is_act     = cmd_valid && (cmd_code == CMD_ACT);
  assign is_wr      = cmd_valid && (cmd_code == CMD_WR);
  assign is_rd      = cmd_valid && (cmd_code == CMD_RD);
  assign is_short_calibration_cmd    = cmd_valid && (cmd_code == CMD_ZQ)
                      && !addr[`ADDR_AP_BIT];
  assign any_cmd    = cmd_valid && (cmd_code != CMD_NOP);

  assign wl         = ctrl[`CTRL_WL_LSB +: `LAT_W];
  assign rl         = ctrl[`CTRL_RL_LSB +: `LAT_W];
  assign chop_fixed = (mr_bl == `BL_FIXED4);
  assign otf_chop   = (mr_bl == `BL_OTF) && !addr[`ADDR_BC_BIT];
  // a fixed chop ends its data two cycles early, all others four
  assign wdelay     = {1'b0, wl} + (chop_fixed ? 6'(`WSTART_CHOP)
                                               : 6'(`WSTART_FULL)); // R6
  assign wtap       = wdelay - 6'h02;
  // only reads and synchronous termination care about the loop
  assign locked_cmd = is_rd || (odt_rise && cke);                   // R11
  assign cke_fall   = cke_q && !cke;
  assign odt_rise   = odt && !odt_q;
  assign odt_fall   = odt_q && !odt;
  assign viol_clr   = reg_write && (reg_addr == `REG_STATUS);

  // timer reload strobes and counts
  always_comb begin
    t_load = '0;
    for (int i = 0; i < `NTIMERS; i++) begin
      t_val[i] = 12'h000;
    end
    // mode sets spaced in real edges, never in elapsed time
    t_load[`T_MRD]   = is_mrs;                                       // R1
    t_val[`T_MRD]    = 12'(`MRD_NCK - 1);
    // exit gaps start when clock enable comes back high
    t_load[`T_XP]    = cke && !cke_q;                                // R18
    t_val[`T_XP]     = XP_CYC - 12'h001;
    t_load[`T_XPDLL] = cke && !cke_q;                                // R17
    t_val[`T_XPDLL]  = XPDLL_CYC - 12'h001;
    t_load[`T_ZQ]    = is_short_calibration_cmd;                                      // R9
    t_val[`T_ZQ]     = 12'(`SHORT_CALIBRATION_CMD_NCK);
    // hold window counts from first high, or from a high with a write
    t_load[`T_ODT]   = odt_rise || (odt && is_wr);                   // R8
    t_val[`T_ODT]    = (is_wr && !chop_fixed && !otf_chop)
                       ? 12'(`ODT_LONG_NCK - 1)                      // R16
                       : 12'(`ODT_SHORT_NCK - 1);                    // R15
    // recovery field already holds whole cycles, so no rounding here
    t_load[`T_WRPD]  = is_wr;                                        // R5
    t_val[`T_WRPD]   = 12'(wdelay) + 12'(mr_wr);                     // R4
    t_load[`T_REF]   = is_ref;                                       // R12
    t_val[`T_REF]    = REF_LIMIT;
    t_load[`T_MPR]   = is_rd && mpr_on;                              // R14
    t_val[`T_MPR]    = 12'(rl) + 12'(`BURST_NCK) + 12'(`MPR_GAP_NCK);
    t_load[`T_BUSY]  = is_act || is_pre || is_ref
                       || (is_wr && addr[`ADDR_AP_BIT])
                       || (is_rd && addr[`ADDR_AP_BIT]);             // R7
    t_val[`T_BUSY]   = 12'(`OP_BUSY_NCK);
  end

  // one counter per tracked spacing
  for (genvar g = 0; g < `NTIMERS; g++) begin : g_timer
    ddrct_timer u_timer (
      .clock      (clock),
      .reset_n    (reset_n),
      .load       (t_load[g]),
      .load_value (t_val[g]),
      .count      (t_cnt[g]),
      .idle       (t_idle[g])                                        // R19
    );
  end

  // mode capture, write start pipeline, refresh arming
  always_comb begin
    next_mr_bl    = mr_bl;
    next_mr_wr    = mr_wr;
    next_mpr_on   = mpr_on;
    next_ref_seen = ref_seen || is_ref;
    if (is_mrs && (ba == `MR0_BANK)) begin
      next_mr_bl = addr[`MR_BL_LSB +: 2];
      next_mr_wr = addr[`MR_WR_LSB +: 3];                            // R4
    end
    if (is_mrs && (ba == `MR3_BANK)) begin
      next_mpr_on = addr[`MR_MPR_BIT];
    end
    next_wchain      = {wchain[32:0], is_wr};
    // history bit j marks a write j+1 cycles back; flag lands on time
    next_write_start = wchain[wtap];                                 // R6
    next_odt_long = t_load[`T_ODT] ? (is_wr && !chop_fixed && !otf_chop)
                                   : odt_long;
  end

  // power-down entry is accepted at once, low power waits for the work
  always_comb begin
    next_pd_state = pd_state;
    unique case (pd_state)
      PD_RUN: begin
        if (cke_fall) begin                                          // R7
          next_pd_state = t_idle[`T_BUSY] ? PD_LOWPWR : PD_DRAIN;
        end
      end
      PD_DRAIN: begin
        if (cke) begin
          next_pd_state = PD_RUN;
        end else if (t_idle[`T_BUSY]) begin
          next_pd_state = PD_LOWPWR;                                 // R7
        end
      end
      PD_LOWPWR: begin
        if (cke) begin
          next_pd_state = PD_RUN;
        end
      end
    endcase
  end

  // violation flags; a new event beats a clear in the same cycle
  always_comb begin
    next_viol = viol;
    if (viol_clr) begin
      next_viol = viol & ~reg_wdata[`NVIOL-1:0];
    end
    if (is_mrs && !t_idle[`T_MRD]) begin
      next_viol[`V_MRD] = 1'b1;                                      // R1
    end
    if (any_cmd && !locked_cmd && !t_idle[`T_XP]) begin
      next_viol[`V_EXIT] = 1'b1;                                     // R18
    end
    if (locked_cmd && !t_idle[`T_XPDLL]) begin
      next_viol[`V_LOCK] = 1'b1;                                     // R17
    end
    if (odt_fall && !t_idle[`T_ODT] && (!odt_long
        || t_cnt[`T_ODT] > 12'(`ODT_LONG_NCK - `ODT_SHORT_NCK))) begin
      next_viol[`V_ODT4] = 1'b1;                                     // R15
    end else if (odt_fall && !t_idle[`T_ODT]) begin
      next_viol[`V_ODT8] = 1'b1;                                     // R16
    end
    // a stopped clock is fine as long as refresh keeps its pace
    if (ref_seen && t_idle[`T_REF] && !is_ref) begin
      next_viol[`V_REF] = 1'b1;                                      // R13
    end
    if (cke_fall && !t_idle[`T_WRPD]) begin
      next_viol[`V_WRPD] = 1'b1;                                     // R5
    end
    if (is_mrs && (ba == `MR3_BANK) && !t_idle[`T_MPR]) begin
      next_viol[`V_MPR] = 1'b1;                                      // R14
    end
  end

  // software registers and the registered read answer
  always_comb begin
    next_ctrl  = ctrl;
    next_rdata = 32'h0000_0000;
    if (reg_write && (reg_addr == `REG_CTRL)) begin
      next_ctrl = reg_wdata;
    end
    if (reg_read) begin
      unique case (reg_addr)
        `REG_CTRL: begin
          next_rdata = ctrl;
        end
        `REG_STATUS: begin
          next_rdata[`NVIOL-1:0]  = viol;
          next_rdata[`ST_LOWPWR]  = (pd_state == PD_LOWPWR);
          next_rdata[`ST_ZQ]      = !t_idle[`T_ZQ];
          next_rdata[`ST_DLL]     = t_idle[`T_XPDLL];
          next_rdata[`ST_MPR]     = mpr_on;
        end
        `REG_MODE: begin
          next_rdata[`MR_BL_LSB +: 2]   = mr_bl;
          next_rdata[`MODE_WR_LSB +: 3] = mr_wr;
        end
        default: begin
          next_rdata = 32'h0000_0000; // unmapped reads as zero
        end
      endcase
    end
  end

  // all state registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl        <= `CTRL_RESET;
      mr_bl       <= `BL_FIXED8;
      mr_wr       <= 3'h0;
      mpr_on      <= 1'b0;
      cke_q       <= 1'b0;
      odt_q       <= 1'b0;
      ref_seen    <= 1'b0;
      viol        <= '0;
      wchain      <= '0;
      odt_long    <= 1'b0;
      write_start <= 1'b0;
      pd_state    <= PD_RUN;
      reg_rdata   <= 32'h0000_0000;
    end else begin
      ctrl        <= next_ctrl;
      mr_bl       <= next_mr_bl;
      mr_wr       <= next_mr_wr;
      mpr_on      <= next_mpr_on;
      cke_q       <= cke;
      odt_q       <= odt;
      ref_seen    <= next_ref_seen;
      viol        <= next_viol;
      wchain      <= next_wchain;
      odt_long    <= next_odt_long;
      write_start <= next_write_start;
      pd_state    <= next_pd_state;
      reg_rdata   <= next_rdata;
    end
  end

  assign low_power     = (pd_state == PD_LOWPWR);
  assign zq_busy       = !t_idle[`T_ZQ];                             // R9
  assign dll_ready     = t_idle[`T_XPDLL];
  // any broken spacing leaves the device needing a full restart
  assign reinit_needed = |viol;                                      // R2

endmodule

// [ddrct_cfg.svh]
// constants of the ddr3 command timing block: offsets, fields, counts
// assumes a 40 MHz clock sampling the command pins on its rising edge
// What this block does
// [R1] spacings count real clock edges, mode sets four apart
// [R2] illegal timing demands reset and full reinitialization
// [R3] nanosecond limits become cycles, divided then rounded up
// [R4] write recovery comes from first mode register field
// [R5] write to power-down gap uses rounded-up recovery
// [R6] internal write starts latency plus four or two
// [R7] accept clock enable low while operations still finish
// [R8] termination hold measured from first high to low
// [R9] short calibration completes within 64 cycles
// [R10] calibration spacing from drift and sensitivity ratio; not tracked here, only the zq_busy length is
// [R11] only read, read-precharge, termination need locked loop
// [R12] at most nine refresh intervals between refreshes
// [R13] no clock period limit beyond refresh interval
// [R14] gap from pattern read end to mode set
// [R15] termination high at least four cycles, short case
// [R16] termination with eight-burst write high six cycles
// [R17] locked commands wait max(10 cycles, 24 ns) after exit
// [R18] other commands wait max(3 cycles, 6 ns) after exit
// [R19] one down-counter per spacing, blocks until zero
`ifndef DDRCT_CFG_SVH
`define DDRCT_CFG_SVH

// clock and conversion
`define TCK_PS          25000
`define PS_PER_NS       1000

// spacings in cycles or nanoseconds, as printed
`define MRD_NCK         4
`define XP_NCK          3
`define XP_NS           6
`define XPDLL_NCK       10
`define XPDLL_NS        24
`define SHORT_CALIBRATION_CMD_NCK        64
`define ODT_SHORT_NCK   4
`define ODT_LONG_NCK    6
`define WSTART_FULL     4
`define WSTART_CHOP     2
`define REFI_NS         7800
`define REF_MAX_GAP     9
`define OP_BUSY_NCK     8
`define MPR_GAP_NCK     1
`define BURST_NCK       4

// timer slots
`define NTIMERS         9
`define T_MRD           0
`define T_XP            1
`define T_XPDLL         2
`define T_ZQ            3
`define T_ODT           4
`define T_WRPD          5
`define T_REF           6
`define T_MPR           7
`define T_BUSY          8

// register offsets
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_MODE        4'h8

// control fields and reset value
`define CTRL_WL_LSB     0
`define CTRL_RL_LSB     8
`define LAT_W           5
`define CTRL_RESET      32'h0000_0505

// mode register fields on the address pins
`define MR_BL_LSB       0
`define MR_WR_LSB       9
`define MR_MPR_BIT      2
`define ADDR_AP_BIT     10
`define ADDR_BC_BIT     12
`define BL_FIXED8       2'h0
`define BL_OTF          2'h1
`define BL_FIXED4       2'h2
`define MR0_BANK        3'h0
`define MR3_BANK        3'h3

// status fields
`define NVIOL           8
`define V_MRD           0
`define V_EXIT          1
`define V_LOCK          2
`define V_ODT4          3
`define V_ODT8          4
`define V_REF           5
`define V_WRPD          6
`define V_MPR           7
`define ST_LOWPWR       8
`define ST_ZQ           9
`define ST_DLL          10
`define ST_MPR          11
`define MODE_WR_LSB     2

`endif

// [ddrct_pkg.sv]
// types shared by the ddr3 command timing block
// assumes the command pins follow the usual cs/ras/cas/we order
package ddrct_pkg;

  // command codes on {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR  = 4'h4,
    CMD_RD  = 4'h5,
    CMD_ZQ  = 4'h6,
    CMD_NOP = 4'h7
  } ddrct_cmd_t;

  // power-down progress, one-hot
  typedef enum logic [2:0] {
    PD_RUN    = 3'b001,
    PD_DRAIN  = 3'b010,
    PD_LOWPWR = 3'b100
  } ddrct_pd_t;

endpackage

// [ddrct_timer.sv]
// one spacing down-counter: loads a cycle count, counts to zero
// assumes load wins over counting in the same cycle
module ddrct_timer (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        load,
  input  wire logic [11:0] load_value,
  output logic      [11:0] count,
  output logic             idle
);

  logic [11:0] next_count; // value after this edge

  // reload on the trigger, otherwise step toward zero
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_value;
    end else if (count != 12'h000) begin
      next_count = count - 12'h001;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= 12'h000;
    end else begin
      count <= next_count;
    end
  end

  assign idle = (count == 12'h000);

endmodule

// [ddrct_ctl_model.sv]
// controller-side command driver facing the ddr3 timing block
// assumes requests change by nonblocking assignment after a rising edge
module ddrct_ctl_model
  import ddrct_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        req_valid, // command wanted at next edge
  input  wire logic [3:0]  req_cmd,   // command code
  input  wire logic [2:0]  req_ba,
  input  wire logic [15:0] req_addr,
  output logic             mrs_ready, // mode-set spacing runs out by the next edge
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic      [2:0]  ba,
  output logic      [15:0] addr
);
  logic [2:0] gap_left;      // edges left before the next mode set
  logic [2:0] next_gap_left; // next count

  // count real edges, reload on every mode set
  always_comb begin
    next_gap_left = (gap_left != 3'h0) ? gap_left - 3'h1 : 3'h0;
    if (req_valid && req_cmd == CMD_MRS) begin
      next_gap_left = 3'h3;
    end
  end

  // register the spacing count
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gap_left <= 3'h0;
    end else begin
      gap_left <= next_gap_left;
    end
  end

  // ready one cycle early: a request lands on the following edge
  assign mrs_ready = (gap_left <= 3'h1);

  // deselected: cs_n forced high, other pins show the inverse, so stale values never look valid
  assign cs_n = req_valid ? req_cmd[3] : 1'b1;
  assign ras_n = req_valid ? req_cmd[2] : ~req_cmd[2];
  assign cas_n = req_valid ? req_cmd[1] : ~req_cmd[1];
  assign we_n = req_valid ? req_cmd[0] : ~req_cmd[0];
  assign ba = req_valid ? req_ba : ~req_ba;
  assign addr = req_valid ? req_addr : ~req_addr;
endmodule

// [ddrct_chk.sv]
// assertions on the ports of the ddr3 command timing block
// assumes one clock domain and the async active-low reset
module ddrct_chk (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [15:0] addr,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        low_power,
  input wire logic        zq_busy,
  input wire logic        dll_ready,
  input wire logic        reinit_needed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // a command counts only with the clock enabled and out of power-down
  wire cmd_taken = cke && !low_power && !cs_n;
  wire mrs_cmd = cmd_taken && {ras_n, cas_n, we_n} == 3'b000;
  wire zq_cmd = cmd_taken && {ras_n, cas_n, we_n} == 3'b110 && !addr[10];

  logic [6:0] zq_len;      // cycles of calibration seen so far
  logic [6:0] next_zq_len; // next count

  // count busy cycles; cleared whenever calibration is idle
  always_comb begin
    next_zq_len = zq_busy ? zq_len + 7'h01 : 7'h00;
  end

  // register the busy length
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      zq_len <= 7'h00;
    end else begin
      zq_len <= next_zq_len;
    end
  end

  AST_ZQ_START: assert property (zq_cmd |=> zq_busy)
    else $error("calibration did not start");
  AST_ZQ_LEN: assert property ($fell(zq_busy) |-> zq_len == 7'h40)
    else $error("calibration not 64 cycles");
  AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_LP_EXIT: assert property (cke && low_power |=> !low_power)
    else $error("low power kept after exit");
  AST_LP_CKE: assert property (low_power |-> !$past(cke))
    else $error("low power without clock enable low");
  AST_LP_ENTRY: assert property ($fell(cke) ##1 (!cke)[*8] ##1 !cke
    |-> low_power)
    else $error("power-down not reached after busy time");
  AST_DLL_GAP: assert property ($rose(cke) |=> (!dll_ready)[*8]
    ##[1:4] dll_ready)
    else $error("locked gap after exit is wrong");
  AST_MRS_VIOL: assert property (mrs_cmd ##3 mrs_cmd |-> ##[1:2] reinit_needed)
    else $error("close mode sets not flagged");
  AST_REINIT_HOLD: assert property (reinit_needed
    && !(reg_write && reg_addr == 4'h4) |=> reinit_needed)
    else $error("reinit flag dropped uncleared");
endmodule

bind ddrct_top ddrct_chk u_chk (.clock, .reset_n, .cke, .cs_n, .ras_n,
  .cas_n, .we_n, .addr, .reg_addr, .reg_write, .reg_read, .reg_rdata,
  .low_power, .zq_busy, .dll_ready, .reinit_needed);

// [tb_top.sv]
// self-checking bench for the ddr3 command timing block
// assumes the controller model drives the command pins
`include "ddrct_cfg.svh"
module tb_top
  import ddrct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock, reset_n, cke, odt;          // clock, reset, pins
  logic        req_valid, reg_write, reg_read;    // request strobes
  ddrct_cmd_t  req_cmd;                           // requested command
  logic [2:0]  req_ba, ba;                        // bank request and pins
  logic [15:0] req_addr, addr;                    // address request and pins
  logic [3:0]  reg_addr;                          // register address
  logic [31:0] reg_wdata, reg_rdata, st, rd;      // register data
  logic        cs_n, ras_n, cas_n, we_n, mrs_ready;
  logic        write_start, low_power, zq_busy, dll_ready, reinit_needed;
  int          errors, n_compared, cycles, k, wl, wr;

  ddrct_top DUT (.clock, .reset_n, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .odt, .ba, .addr, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .write_start, .low_power, .zq_busy, .dll_ready,
    .reinit_needed);

  ddrct_ctl_model u_ctl (.clock, .reset_n, .req_valid, .req_cmd, .req_ba,
    .req_addr, .mrs_ready, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);

  // free-running 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // hang guard, far above the run's length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      close_out();
    end
  end

  // expected internal write start delay
  function automatic int wdelay(int w, int m);
    return w + ((m == 2) ? `WSTART_CHOP : `WSTART_FULL);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // one command; mode sets wait for the spacing unless bad is set
  task automatic cmd(input ddrct_cmd_t c, input logic [15:0] a,
                     input logic bad);
    @(negedge clock);
    while (c == CMD_MRS && !bad && mrs_ready !== 1'b1) begin
      @(negedge clock);
    end
    @(posedge clock);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    {reset_n, cke, odt, req_valid, reg_write, reg_read} = 6'h10;
    req_cmd = CMD_NOP;
    req_ba = 3'h0;
    req_addr = 16'h0000;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    void'($urandom(58118));
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (12) @(posedge clock);
    reg_rd(4'h0, rd);
    check(rd, 32'h0000_0505);
    reg_rd(4'h4, rd);
    check(rd, 32'h0000_0400);
    reg_rd(4'h8, rd);
    check(rd, 32'h0000_0000);
    reg_rd(4'hC, rd);
    check(rd, 32'h0000_0000);
    $display("reset values done");
    // every burst mode, random latency and recovery field
    for (int m = 0; m < 3; m++) begin
      wl = 5 + $urandom_range(7);
      wr = $urandom_range(7);
      st = ($urandom & 32'hFFFF_E0E0) | 32'h0000_0500 | 32'(wl);
      reg_wr(4'h0, st);
      reg_rd(4'h0, rd);
      check(rd, st);
      cmd(CMD_MRS, 16'(wr * 512 + m), 1'b0);
      reg_rd(4'h8, rd);
      check(rd, 32'(wr * 4 + m));
      cmd(CMD_WR, 16'h0000, 1'b0); // chop on the fly in mode 1
      k = 0;
      while (write_start !== 1'b1 && k < 40) begin
        k++;
        @(negedge clock);
      end
      check(k + 1, wdelay(wl, m));
    end
    $display("write start done");
    reg_wr(4'h4, 32'h0000_00FF);
    cmd(CMD_MRS, 16'h0000, 1'b0);
    cmd(CMD_MRS, 16'h0000, 1'b0);
    reg_rd(4'h4, rd);
    check(rd, 32'h0000_0400);
    cmd(CMD_MRS, 16'h0000, 1'b0);
    cmd(CMD_MRS, 16'h0000, 1'b1); // three edges apart on purpose
    reg_rd(4'h4, rd);
    check(rd, 32'h0000_0401);
    check(reinit_needed, 1'b1);
    reg_wr(4'h4, 32'h0000_0001);
    reg_rd(4'h4, rd);
    check(rd, 32'h0000_0400);
    $display("mode set spacing done");
    cmd(CMD_ZQ, 16'h0000, 1'b0);
    k = 0;
    repeat (2) if (zq_busy !== 1'b1) @(negedge clock);
    while (zq_busy === 1'b1 && k < 100) begin
      k++;
      @(negedge clock);
    end
    check(k, `SHORT_CALIBRATION_CMD_NCK);
    $display("calibration done");
    // clock enable drops while a row activation is still busy
    cmd(CMD_ACT, 16'h0000, 1'b0);
    @(posedge clock);
    cke <= 1'b0;
    repeat (3) @(negedge clock);
    check(low_power, 1'b0);
    k = 0;
    while (low_power !== 1'b1 && k < 12) begin
      k++;
      @(negedge clock);
    end
    check(low_power, 1'b1);
    repeat (10) @(posedge clock);
    cke <= 1'b1;
    repeat (2) @(negedge clock);
    check(low_power, 1'b0);
    k = 0;
    while (dll_ready !== 1'b1 && k < 20) begin
      k++;
      @(negedge clock);
    end
    check(k + 1, `XPDLL_NCK);
    // a read right after exit breaks only the locked gap
    reg_wr(4'h4, 32'h0000_00FF);
    @(posedge clock);
    cke <= 1'b0;
    repeat (3) @(posedge clock);
    cke <= 1'b1;
    cmd(CMD_RD, 16'h0000, 1'b0);
    repeat (12) @(posedge clock);
    reg_rd(4'h4, rd);
    check(rd[7:0], 8'h04);
    $display("power-down done");
    // termination held 3..6 edges, with a full write from the third
    for (int i = 0; i < 4; i++) begin
      reg_wr(4'h4, 32'h0000_00FF);
      @(posedge clock);
      odt <= 1'b1;
      req_valid <= i[1];
      req_cmd <= CMD_WR;
      @(posedge clock);
      req_valid <= 1'b0;
      repeat (i + 2) @(posedge clock);
      odt <= 1'b0;
      repeat (4) @(posedge clock);
      reg_rd(4'h4, rd);
      k = i[1] ? `ODT_LONG_NCK : `ODT_SHORT_NCK;
      check(rd[7:0], (i + 3 < k) ? (i[1] ? 8'h10 : 8'h08) : 8'h00);
    end
    $display("termination hold done");
    k = `REF_MAX_GAP * (`REFI_NS * `PS_PER_NS / `TCK_PS);
    reg_wr(4'h4, 32'h0000_00FF);
    cmd(CMD_REF, 16'h0000, 1'b0);
    repeat (k - 30) @(posedge clock);
    reg_rd(4'h4, rd);
    check(rd[7:0], 8'h00);
    repeat (60) @(posedge clock);
    reg_rd(4'h4, rd);
    check(rd[7:0], 8'h20);
    $display("refresh gap done");
    close_out();
  end
endmodule
